// ===== logic/tpio_pkg.sv
// Purpose: Shared constants and types of the timer pin I/O mode block
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes:   Pin index 0 is channel 2 A, 1 is channel 2 B, 2 is channel 3 B
`default_nettype none
package tpio_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int GR_W   = 16;
    localparam int CODE_W = 4;
    localparam int CTRL_W = 8;
    localparam int NPIN   = 3;
    localparam int NEV    = 6;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL2  = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL3H = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_GR2A   = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_GR2B   = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_GR3B   = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT   = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 5'h18;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [GR_W-1:0]   GR_RST   = 16'h0000;
    localparam logic [NEV-1:0]    EV_RST   = 6'h00;
    localparam logic              PIN_RST  = 1'b0;

    // Field positions
    localparam int CODE_A_LSB    = 0;
    localparam int CODE_B_LSB    = 4;
    localparam int CODE_IN_BIT   = 3;
    localparam int CODE_LVL_BIT  = 2;
    localparam int CODE_BOTH_BIT = 1;
    localparam int CODE_FALL_BIT = 0;
    localparam int STAT_CMP_LSB  = 0;
    localparam int STAT_CAP_LSB  = 3;

    // Compare actions in the two low code bits
    localparam logic [1:0] ACT_HOLD   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    typedef struct packed {
        logic ch3_b;
        logic ch2_b;
        logic ch2_a;
    } tpio_pins_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } tpio_bus_t;
endpackage
`default_nettype wire

// ===== logic/tpio_top.sv
// Purpose: Pin I/O mode select for timer channel 2 A/B and channel 3 B
// Assumes: Compare strobes and counters come from the timer counter logic
// Notes:   One bus request is answered with waitrequest low one cycle later
//
// Functional notes
// - 0000/0100 hold pin; 0001 start low, match low
// - 0010 start low, 0110 start high; match high
// - 0011 start low, 0111 start high; match toggles
// - 1x00 captures counter on rising pin edge
// - 1x01 captures counter on falling pin edge
// - 1x1x captures counter on both pin edges
// - Pin low after reset until code written
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tpio_top (
    input  wire logic                                       CLK,
    input  wire logic                                       RST,
    input  wire logic [tpio_pkg::ADDR_W-1:0]                AVS_ADDRESS,
    input  wire logic                                       AVS_READ,
    input  wire logic                                       AVS_WRITE,
    input  wire logic [tpio_pkg::DATA_W-1:0]                AVS_WRITEDATA,
    input  wire logic [tpio_pkg::BE_W-1:0]                  AVS_BYTEENABLE,
    output logic      [tpio_pkg::DATA_W-1:0]                AVS_READDATA,
    output logic                                            AVS_WAITREQUEST,
    output logic                                            IRQ,
    input  wire logic [tpio_pkg::GR_W-1:0]                  CNT_CH2,
    input  wire logic [tpio_pkg::GR_W-1:0]                  CNT_CH3,
    input  wire tpio_pkg::tpio_pins_t                       CMP_MATCH,
    input  wire tpio_pkg::tpio_pins_t                       PIN_IN,
    output tpio_pkg::tpio_pins_t                            PIN_OUT,
    output tpio_pkg::tpio_pins_t                            PIN_OE,
    output logic [tpio_pkg::NPIN-1:0][tpio_pkg::GR_W-1:0]   GR_VALUE
);
    import tpio_pkg::*;

    function automatic logic [GR_W-1:0] merge16(
        input logic [GR_W-1:0]   old,
        input logic [DATA_W-1:0] wd,
        input logic [BE_W-1:0]   be
    );
        logic [GR_W-1:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // Output modes have the input bit clear; the pin is driven then
    function automatic logic is_out(input logic [CODE_W-1:0] code);
        return !code[CODE_IN_BIT];
    endfunction

    // Output codes other than hold carry a start level in one bit
    function automatic logic sets_start(input logic [CODE_W-1:0] code);
        return is_out(code) && (code[1:0] != ACT_HOLD);
    endfunction

    // Input codes pick which of the two settled edges loads the register
    function automatic logic cap_hit(
        input logic [CODE_W-1:0] code,
        input logic              up,
        input logic              down
    );
        logic hit;
        if (code[CODE_BOTH_BIT]) begin
            hit = up || down;
        end else if (code[CODE_FALL_BIT]) begin
            hit = down;
        end else begin
            hit = up;
        end
        return hit;
    endfunction

    // Bus handshake
    tpio_bus_t          state_r;
    tpio_bus_t          state_nxt;
    logic               wait_r;
    logic               wait_nxt;
    logic [DATA_W-1:0]  rdata_r;
    logic [DATA_W-1:0]  rdata_nxt;
    logic [DATA_W-1:0]  rd_mux;
    logic               wr_en;

    // Register file
    logic [CTRL_W-1:0]  ctrl2_r;
    logic [CTRL_W-1:0]  ctrl2_nxt;
    logic [CTRL_W-1:0]  ctrl3_r;
    logic [CTRL_W-1:0]  ctrl3_nxt;
    logic [GR_W-1:0]    gr_r   [NPIN];
    logic [GR_W-1:0]    gr_nxt [NPIN];
    logic [NEV-1:0]     stat_r;
    logic [NEV-1:0]     stat_nxt;
    logic [NEV-1:0]     mask_r;
    logic [NEV-1:0]     mask_nxt;
    logic               irq_r;
    logic               irq_nxt;
    logic [ADDR_W-1:0]  gr_off [NPIN];

    // Pin side
    logic [CODE_W-1:0]  code_r  [NPIN];
    logic [CODE_W-1:0]  code_n  [NPIN];
    logic               code_wr [NPIN];
    logic [GR_W-1:0]    cnt     [NPIN];
    logic               lvl_r   [NPIN];
    logic               lvl_nxt [NPIN];
    logic               oe_r    [NPIN];
    logic               s1_r    [NPIN];
    logic               s2_r    [NPIN];
    logic               s3_r    [NPIN];
    logic               cmp_ev  [NPIN];
    logic               cap_ev  [NPIN];

    assign wr_en = AVS_WRITE && (state_r == BUS_ACK);

    always_comb begin
        rd_mux = '0;
        case (AVS_ADDRESS)
            OFF_CTRL2:  rd_mux[CTRL_W-1:0] = ctrl2_r;
            OFF_CTRL3H: rd_mux[CTRL_W-1:0] = ctrl3_r;
            OFF_GR2A:   rd_mux[GR_W-1:0]   = gr_r[0];
            OFF_GR2B:   rd_mux[GR_W-1:0]   = gr_r[1];
            OFF_GR3B:   rd_mux[GR_W-1:0]   = gr_r[2];
            OFF_STAT:   rd_mux[NEV-1:0]    = stat_r;
            OFF_MASK:   rd_mux[NEV-1:0]    = mask_r;
            default:    rd_mux = '0;
        endcase
    end

    // Read data is latched on entry to the answer cycle and held there
    always_comb begin
        state_nxt = state_r;
        rdata_nxt = rdata_r;
        case (state_r)
            BUS_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    state_nxt = BUS_ACK;
                    rdata_nxt = AVS_READ ? rd_mux : '0;
                end
            end
            BUS_ACK: state_nxt = BUS_IDLE;
            default: state_nxt = BUS_IDLE;
        endcase
        wait_nxt = (state_nxt != BUS_ACK);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= BUS_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Per-pin code nibbles and counter sources
    always_comb begin
        code_r[0]  = ctrl2_r[CODE_A_LSB +: CODE_W];
        code_r[1]  = ctrl2_r[CODE_B_LSB +: CODE_W];
        code_r[2]  = ctrl3_r[CODE_B_LSB +: CODE_W];
        code_n[0]  = ctrl2_nxt[CODE_A_LSB +: CODE_W];
        code_n[1]  = ctrl2_nxt[CODE_B_LSB +: CODE_W];
        code_n[2]  = ctrl3_nxt[CODE_B_LSB +: CODE_W];
        code_wr[0] = wr_en && (AVS_ADDRESS == OFF_CTRL2) && AVS_BYTEENABLE[0];
        code_wr[1] = code_wr[0];
        code_wr[2] = wr_en && (AVS_ADDRESS == OFF_CTRL3H)
                     && AVS_BYTEENABLE[0];
        cnt[0]     = CNT_CH2;
        cnt[1]     = CNT_CH2;
        cnt[2]     = CNT_CH3;
        gr_off[0]  = OFF_GR2A;
        gr_off[1]  = OFF_GR2B;
        gr_off[2]  = OFF_GR3B;
    end

    // Registers; a hardware event wins over a clear in the same cycle
    always_comb begin
        ctrl2_nxt = ctrl2_r;
        ctrl3_nxt = ctrl3_r;
        mask_nxt  = mask_r;
        stat_nxt  = stat_r;
        if (code_wr[0]) begin
            ctrl2_nxt = AVS_WRITEDATA[CTRL_W-1:0];
        end
        if (code_wr[2]) begin
            ctrl3_nxt = AVS_WRITEDATA[CTRL_W-1:0];
        end
        if (wr_en && (AVS_ADDRESS == OFF_MASK) && AVS_BYTEENABLE[0]) begin
            mask_nxt = AVS_WRITEDATA[NEV-1:0];
        end
        if (wr_en && (AVS_ADDRESS == OFF_STAT) && AVS_BYTEENABLE[0]) begin
            stat_nxt = stat_r & ~AVS_WRITEDATA[NEV-1:0];
        end
        for (int i = 0; i < NPIN; i++) begin
            stat_nxt[STAT_CMP_LSB + i] = stat_nxt[STAT_CMP_LSB + i]
                                         | cmp_ev[i];
            stat_nxt[STAT_CAP_LSB + i] = stat_nxt[STAT_CAP_LSB + i]
                                         | cap_ev[i];
            gr_nxt[i] = gr_r[i];
            if (wr_en && (AVS_ADDRESS == gr_off[i])) begin
                gr_nxt[i] = merge16(gr_r[i], AVS_WRITEDATA, AVS_BYTEENABLE);
            end
            // Capture beats a software write in the same cycle
            if (cap_ev[i]) begin
                gr_nxt[i] = cnt[i];
            end
        end
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl2_r <= CTRL_RST;
            ctrl3_r <= CTRL_RST;
            mask_r  <= EV_RST;
            stat_r  <= EV_RST;
            irq_r   <= 1'b0;
            for (int i = 0; i < NPIN; i++) begin
                gr_r[i] <= GR_RST;
            end
        end else begin
            ctrl2_r <= ctrl2_nxt;
            ctrl3_r <= ctrl3_nxt;
            mask_r  <= mask_nxt;
            stat_r  <= stat_nxt;
            irq_r   <= irq_nxt;
            for (int i = 0; i < NPIN; i++) begin
                gr_r[i] <= gr_nxt[i];
            end
        end
    end

    // Pin logic, one copy per pin
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        logic rise;
        logic fall;
        logic oe_nxt;

        // Edges only look at the settled stages, never the first one
        assign rise   = s2_r[g] && !s3_r[g];
        assign fall   = !s2_r[g] && s3_r[g];
        assign oe_nxt = is_out(code_n[g]);

        always_comb begin
            lvl_nxt[g] = lvl_r[g];
            cmp_ev[g]  = 1'b0;
            cap_ev[g]  = 1'b0;
            if (is_out(code_r[g])) begin
                if (CMP_MATCH[g]) begin
                    cmp_ev[g] = 1'b1;
                    case (code_r[g][1:0])
                        ACT_HOLD:   lvl_nxt[g] = lvl_r[g];
                        ACT_LOW:    lvl_nxt[g] = 1'b0;
                        ACT_HIGH:   lvl_nxt[g] = 1'b1;
                        ACT_TOGGLE: lvl_nxt[g] = !lvl_r[g];
                        default:    lvl_nxt[g] = lvl_r[g];
                    endcase
                end
            end else begin
                cap_ev[g] = cap_hit(code_r[g], rise, fall);
            end
            // A fresh output code sets its start level at once
            if (code_wr[g] && sets_start(code_n[g])) begin
                lvl_nxt[g] = code_n[g][CODE_LVL_BIT];
            end
        end

        always_ff @(posedge CLK) begin
            if (RST) begin
                lvl_r[g] <= PIN_RST;
                oe_r[g]  <= 1'b0;
                s1_r[g]  <= 1'b0;
                s2_r[g]  <= 1'b0;
                s3_r[g]  <= 1'b0;
            end else begin
                lvl_r[g] <= lvl_nxt[g];
                oe_r[g]  <= oe_nxt;
                s1_r[g]  <= PIN_IN[g];
                s2_r[g]  <= s1_r[g];
                s3_r[g]  <= s2_r[g];
            end
        end
    end

    // Outputs straight from flip-flops
    always_comb begin
        AVS_READDATA    = rdata_r;
        AVS_WAITREQUEST = wait_r;
        IRQ             = irq_r;
        for (int i = 0; i < NPIN; i++) begin
            PIN_OUT[i]  = lvl_r[i];
            PIN_OE[i]   = oe_r[i];
            GR_VALUE[i] = gr_r[i];
        end
    end
endmodule
`default_nettype wire

// ===== sim/tpio_sva.sv
// Purpose: Bus and pin 2A timing checks for the pin I/O mode block
// Assumes: Control of channel 2 mirrored from committed bus writes
// Notes:   Pin 2A stands in for all pins; the logic is shared
`timescale 1ns/1ps
`default_nettype none
module tpio_sva
    import tpio_pkg::*;
(
    input wire logic                          CLK,
    input wire logic                          RST,
    input wire logic [ADDR_W-1:0]             AVS_ADDRESS,
    input wire logic                          AVS_READ,
    input wire logic                          AVS_WRITE,
    input wire logic [DATA_W-1:0]             AVS_WRITEDATA,
    input wire logic [BE_W-1:0]               AVS_BYTEENABLE,
    input wire logic                          AVS_WAITREQUEST,
    input wire logic [GR_W-1:0]               CNT_CH2,
    input wire tpio_pins_t                    CMP_MATCH,
    input wire tpio_pins_t                    PIN_IN,
    input wire tpio_pins_t                    PIN_OUT,
    input wire tpio_pins_t                    PIN_OE,
    input wire logic [NPIN-1:0][GR_W-1:0]     GR_VALUE
);
    logic       wr2;
    logic       om;
    logic [7:0] c2_r;
    logic [7:0] c2_nxt;
    assign wr2 = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
                 && AVS_ADDRESS == OFF_CTRL2;
    assign om = CMP_MATCH.ch2_a && !c2_r[3] && !wr2;
    always_comb c2_nxt = wr2 ? AVS_WRITEDATA[7:0] : c2_r;
    always_ff @(posedge CLK) c2_r <= RST ? 8'h00 : c2_nxt;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // A request always gets exactly one wait cycle
    a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("bus answer");
    a_hold_keep: assert property (om && c2_r[1:0] == 2'h0
        |=> $stable(PIN_OUT.ch2_a)) else $error("hold moved pin");
    a_match_low: assert property (om && c2_r[1:0] == 2'h1
        |=> !PIN_OUT.ch2_a) else $error("match low");
    a_match_high: assert property (om && c2_r[1:0] == 2'h2
        |=> PIN_OUT.ch2_a) else $error("match high");
    a_match_toggle: assert property (om && c2_r[1:0] == 2'h3
        |=> PIN_OUT.ch2_a != $past(PIN_OUT.ch2_a)) else $error("toggle");
    a_init_level: assert property (wr2 && !AVS_WRITEDATA[3]
        && AVS_WRITEDATA[1:0] != 2'h0 |=> PIN_OUT.ch2_a == c2_r[2])
        else $error("initial level");
    a_reset_low: assert property ($past(RST)
        |-> PIN_OUT == 3'h0 && PIN_OE == 3'h0) else $error("reset pins");
    // Two sync flops plus edge detect give three edges to the load
    a_cap_rise: assert property (c2_r[3] && c2_r[1:0] == 2'h0 && !wr2
        && $rose(PIN_IN.ch2_a) |-> ##3 GR_VALUE[0] == $past(CNT_CH2))
        else $error("rising capture");
    c_init: cover property (wr2 && !AVS_WRITEDATA[3]);
    c_toggle: cover property (om && c2_r[1:0] == 2'h3);
    c_fall: cover property (c2_r[3] && $fell(PIN_IN.ch2_a));
endmodule
bind tpio_top tpio_sva sva_u (.CLK(CLK), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CNT_CH2(CNT_CH2),
    .CMP_MATCH(CMP_MATCH), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .GR_VALUE(GR_VALUE));
`default_nettype wire

// ===== sim/tpio_pin_model.sv
// Purpose: Far-side sources on the three timer pins
// Assumes: An outside source always drives a released pin
// Notes:   No pull resistors, so the released level is the source's
`timescale 1ns/1ps
`default_nettype none
module tpio_pin_model (
    input  wire tpio_pkg::tpio_pins_t drv,
    input  wire tpio_pkg::tpio_pins_t oe,
    input  wire tpio_pkg::tpio_pins_t ext,
    output var  tpio_pkg::tpio_pins_t pin
);
    import tpio_pkg::*;
    // Block drive wins while enabled, else the outside source
    assign pin = (drv & oe) | (ext & ~oe);
endmodule
`default_nettype wire

// ===== sim/tb_timer_pin_io_mode_select.sv
// Purpose: Self-checking bench for the pin I/O mode block
// Assumes: Outputs read at the clock edge see the previous cycle
// Notes:   Free-running counter gives every capture its own value
`timescale 1ns/1ps
`default_nettype none
module tb_timer_pin_io_mode_select;
    import tpio_pkg::*;
    logic                      clk, rst, rd, wr, wtr, irq;
    logic [ADDR_W-1:0]         adr;
    logic [DATA_W-1:0]         wd, rdat;
    logic [GR_W-1:0]           cnt, c0;
    logic [2:0]                lv;
    logic [3:0]                cd [3];
    logic [NPIN-1:0][GR_W-1:0] grv;
    tpio_pins_t                cmp, pin, pout, poe, ext;
    int                        num_errors, check_count;
    tpio_top dut_u (.CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wtr), .IRQ(irq),
        .CNT_CH2(cnt), .CNT_CH3(~cnt), .CMP_MATCH(cmp), .PIN_IN(pin),
        .PIN_OUT(pout), .PIN_OE(poe), .GR_VALUE(grv));
    tpio_pin_model pm_u (.drv(pout), .oe(poe), .ext(ext), .pin(pin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cnt <= cnt + 16'h0001;
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t got %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, input logic [31:0] e);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wtr !== 1'b0);
        if (!w) cmp32(rdat, e);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    // Settle the released pin first; the load comes three edges after ext changes
    task automatic drive_ext(input logic [2:0] v);
        repeat (2) @(posedge clk);
        ext <= v;
        c0 = cnt;
        repeat (6) @(posedge clk);
    endtask
    function automatic logic f_lvl(input logic [3:0] c, input logic p,
                                   input logic m);
        if (!m) return (c[1:0] == 2'h0) ? p : c[2];
        case (c[1:0])
            2'h0: return p;
            2'h1: return 1'b0;
            2'h2: return 1'b1;
            default: return !p;
        endcase
    endfunction
    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = '0; wd = '0; cnt = '0;
        cmp = '0; ext = '0; num_errors = 0; check_count = 0; lv = 3'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cmp32({29'h0, pout}, 32'h0);
        bus(1'b0, OFF_CTRL2, 32'h0, 32'h0);
        for (int i = 0; i < 8; i++) begin
            cd[0] = 4'(i);
            cd[1] = 4'(7 - i);
            cd[2] = 4'(i);
            bus(1'b1, OFF_CTRL2, {24'h0, cd[1], cd[0]}, 32'h0);
            bus(1'b1, OFF_CTRL3H, {24'h0, cd[2], 4'h0}, 32'h0);
            for (int p = 0; p < 3; p++) lv[p] = f_lvl(cd[p], lv[p], 1'b0);
            cmp32({29'h0, pout}, {29'h0, lv});
            cmp32({29'h0, poe}, 32'h7);
            cmp <= 3'h7;
            @(posedge clk);
            cmp <= 3'h0;
            @(posedge clk);
            for (int p = 0; p < 3; p++) lv[p] = f_lvl(cd[p], lv[p], 1'b1);
            cmp32({29'h0, pout}, {29'h0, lv});
        end
        bus(1'b1, OFF_CTRL2, 32'h11, 32'h0);
        bus(1'b1, OFF_CTRL2, 32'h9C, 32'h0);
        drive_ext(3'h3);
        cmp32({30'h0, poe.ch2_b, poe.ch2_a}, 32'h0);
        bus(1'b0, OFF_GR2A, 32'h0, {16'h0, c0 + 16'h0003});
        bus(1'b0, OFF_GR2B, 32'h0, 32'h0);
        drive_ext(3'h0);
        bus(1'b0, OFF_GR2B, 32'h0, {16'h0, c0 + 16'h0003});
        bus(1'b1, OFF_CTRL2, 32'hBE, 32'h0);
        drive_ext(3'h3);
        bus(1'b0, OFF_GR2A, 32'h0, {16'h0, c0 + 16'h0003});
        drive_ext(3'h0);
        bus(1'b0, OFF_GR2B, 32'h0, {16'h0, c0 + 16'h0003});
        bus(1'b1, OFF_CTRL3H, 32'h80, 32'h0);
        drive_ext(3'h4);
        bus(1'b0, OFF_GR3B, 32'h0, {16'h0, ~(c0 + 16'h0003)});
        bus(1'b1, OFF_MASK, 32'h08, 32'h0);
        @(posedge clk);
        cmp32({31'h0, irq}, 32'h1);
        bus(1'b1, OFF_STAT, 32'h3F, 32'h0);
        @(posedge clk);
        cmp32({31'h0, irq}, 32'h0);
        bus(1'b0, OFF_MASK, 32'h0, 32'h08);
        bus(1'b0, 5'h1C, 32'h0, 32'h0);
        finish_test();
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
